//--- rtl/sro_defs.vh
`ifndef SRO_DEFS_VH
`define SRO_DEFS_VH
// ------------------------------------------------------------
// register byte offsets
// ------------------------------------------------------------
`define SRO_OFF_CTRL 12'h000
`define SRO_OFF_SEL 12'h004
`define SRO_OFF_STAT 12'h008
`define SRO_OFF_OPT 12'h00C
`define SRO_OFF_RSTCAUSE 12'h010
`define SRO_OFF_IRQST 12'h014
`define SRO_OFF_IRQMSK 12'h018
// ------------------------------------------------------------
// control register fields
// ------------------------------------------------------------
`define SRO_CTRL_IDLE 0
`define SRO_CTRL_OSCOFF 1
`define SRO_CTRL_CPUSRC_LO 2
`define SRO_CTRL_XTAL_EN 4
// cpu clock source codes
`define SRO_SRC_FAST 2'h0
`define SRO_SRC_SUB 2'h1
`define SRO_SRC_XTAL 2'h2
// ------------------------------------------------------------
// option byte locations and fields, illegal opcode
// ------------------------------------------------------------
`define SRO_OPT_PRI_ADDR 20'h000C0
`define SRO_OPT_ALT_ADDR 20'h010C0
`define SRO_OPT_BYTES 3'h4
`define SRO_WDT_IRQ_BIT 7
`define SRO_RESERVED_OPT 8'hFF
`define SRO_ILLEGAL_OPCODE 8'hFF
// ------------------------------------------------------------
// reset values and timing
// ------------------------------------------------------------
`define SRO_SEL_RESET 3'h7
`define SRO_STAB_BASE_CYC 256
`define SRO_RST_STRETCH 4'hF
`endif

//--- rtl/sro_sync.v
module sro_sync #(
  parameter WIDTH = 1
) (
  input wire clock,
  input wire rst_b,
  input wire [WIDTH-1:0] async_in,
  output reg [WIDTH-1:0] sync_out
);
  reg [WIDTH-1:0] s1_reg;
  reg [WIDTH-1:0] s2_reg;
  reg [WIDTH-1:0] s3_reg;
  genvar i;
  // ------------------------------------------------------------
  // three stages, change taken once stage two and three agree
  // ------------------------------------------------------------
  always @(posedge clock) begin
    if (!rst_b) begin
      s1_reg <= {WIDTH{1'b0}};
      s2_reg <= {WIDTH{1'b0}};
      s3_reg <= {WIDTH{1'b0}};
    end else begin
      s1_reg <= async_in;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
    end
  end
  generate
    for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
      always @(posedge clock) begin
        if (!rst_b) begin
          sync_out[i] <= 1'b0;
        end else if (s2_reg[i] == s3_reg[i]) begin
          sync_out[i] <= s3_reg[i];
        end
      end
    end
  endgenerate
endmodule

//--- rtl/sro_stab_counter.v
module sro_stab_counter #(
  parameter BASE = 256
) (
  input wire clock,
  input wire rst_b,
  input wire start,
  input wire [2:0] sel,
  output reg [7:0] progress,
  output reg done
);
  reg [18:0] count_reg;
  reg [18:0] limit;
  reg running_reg;
  integer k;
  // ------------------------------------------------------------
  // limit doubles per select step
  // ------------------------------------------------------------
  always @* begin
    limit = BASE[18:0] << sel;
  end
  always @(posedge clock) begin
    if (!rst_b) begin
      count_reg <= 19'h00000;
      running_reg <= 1'b0;
      done <= 1'b0;
      progress <= 8'h00;
    end else if (start) begin
      count_reg <= 19'h00000;
      running_reg <= 1'b1;
      done <= 1'b0;
      progress <= 8'h00;
    end else if (running_reg) begin
      count_reg <= count_reg + 19'h00001;
      for (k = 0; k < 8; k = k + 1) begin
        if (count_reg + 19'h00001 >= (BASE[18:0] << k)) begin
          progress[k] <= 1'b1;
        end
      end
      if (count_reg + 19'h00001 >= limit) begin
        running_reg <= 1'b0;
        done <= 1'b1;
      end
    end
  end
endmodule

//--- rtl/sro_standby_reset.v
`include "sro_defs.vh"
module sro_standby_reset #(
  parameter STAB_BASE = `SRO_STAB_BASE_CYC
) (
  input wire clock,
  input wire rst_b,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire extResetPin_b,
  input wire powerOnClear,
  input wire supplyDropReset,
  input wire watchdogLoopReset,
  input wire opcodeValid,
  input wire [7:0] opcode,
  input wire wakeEvent,
  input wire bootSwap,
  output reg [19:0] flashAddr,
  output reg flashRead,
  input wire [7:0] flashData,
  input wire flashDataValid,
  output reg systemReset,
  output reg cpuClockEnable,
  output reg mainOscEnable,
  output reg optLoaded,
  output reg [6:0] watchdogConfig,
  output reg watchdogIntervalIrqEnable,
  output reg supplyDropDetectorDefaultOn,
  output reg debugEnable,
  output reg debugEraseOnAuthFail,
  output reg irq
);
  // ------------------------------------------------------------
  // state encodings
  // ------------------------------------------------------------
  localparam [3:0] ST_RUN = 4'h1;
  localparam [3:0] ST_IDLE = 4'h2;
  localparam [3:0] ST_OSCOFF = 4'h4;
  localparam [3:0] ST_WAKE = 4'h8;
  localparam [2:0] LD_IDLE = 3'h1;
  localparam [2:0] LD_REQ = 3'h2;
  localparam [2:0] LD_DONE = 3'h4;
  reg [3:0] pwrState_reg;
  reg [2:0] ldState_reg;
  reg [1:0] byteIdx_reg;
  reg [7:0] optByte0_reg;
  reg [7:0] optByte1_reg;
  reg [7:0] optByte2_reg;
  reg [7:0] optByte3_reg;
  reg [3:0] rstStretch_reg;
  reg [4:0] rstCause_reg;
  reg [1:0] irqStatus_reg;
  reg [1:0] irqMask_reg;
  reg [2:0] stab_time_select_reg;
  reg [1:0] cpuSrc_reg;
  reg xtalEn_reg;
  reg xtalEnPrev_reg;
  reg stabStart;
  wire [7:0] stab_count_status;
  wire stabDone;
  wire [3:0] pinSync;
  wire extReset;
  wire illegalOp;
  wire [4:0] rstSrc;
  wire anyReset;
  wire apbWrite;
  wire apbRead;
  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  function hit;
    input [11:0] a;
    input [11:0] off;
    begin
      hit = (a == off);
    end
  endfunction
  // ------------------------------------------------------------
  // input synchronisers and reset sources
  // ------------------------------------------------------------
  sro_sync #(.WIDTH(4)) u_sync (
    .clock(clock),
    .rst_b(rst_b),
    .async_in({~extResetPin_b, powerOnClear, supplyDropReset, wakeEvent}),
    .sync_out(pinSync)
  );
  assign extReset = pinSync[3];
  assign illegalOp = opcodeValid && (opcode == `SRO_ILLEGAL_OPCODE);
  // pin, watchdog, power-on-clear, supply-drop, illegal opcode
  assign rstSrc = {extReset, watchdogLoopReset, pinSync[2], pinSync[1], illegalOp};
  assign anyReset = |rstSrc;
  // ------------------------------------------------------------
  // stabilisation counter
  // ------------------------------------------------------------
  sro_stab_counter #(.BASE(STAB_BASE)) u_stab (
    .clock(clock),
    .rst_b(rst_b),
    .start(stabStart),
    .sel(stab_time_select_reg),
    .progress(stab_count_status),
    .done(stabDone)
  );

  assign apbWrite = psel && penable && pwrite && !systemReset;
  assign apbRead = psel && penable && !pwrite;

  // ------------------------------------------------------------
  // reset stretch and cause capture
  // ------------------------------------------------------------
  always @(posedge clock) begin
    if (!rst_b) begin
      rstStretch_reg <= `SRO_RST_STRETCH;
      systemReset <= 1'b1;
      rstCause_reg <= 5'h00;
    end else if (anyReset) begin
      rstStretch_reg <= `SRO_RST_STRETCH;
      systemReset <= 1'b1;
      rstCause_reg <= rstCause_reg | rstSrc;
    end else begin
      if (rstStretch_reg != 4'h0) begin
        rstStretch_reg <= rstStretch_reg - 4'h1;
      end
      systemReset <= (rstStretch_reg != 4'h0) || (ldState_reg != LD_DONE);
      if (apbRead && !pready && hit(paddr, `SRO_OFF_RSTCAUSE)) begin
        rstCause_reg <= 5'h00;
      end
    end
  end

  // ------------------------------------------------------------
  // option byte loader
  // ------------------------------------------------------------
  always @(posedge clock) begin
    if (!rst_b || anyReset) begin
      ldState_reg <= LD_IDLE;
      byteIdx_reg <= 2'h0;
      flashRead <= 1'b0;
      flashAddr <= 20'h00000;
      optLoaded <= 1'b0;
    end else begin
      case (ldState_reg)
        LD_IDLE: begin
          if (rstStretch_reg == 4'h0) begin
            ldState_reg <= LD_REQ;
            flashRead <= 1'b1;
            flashAddr <= (bootSwap ? `SRO_OPT_ALT_ADDR : `SRO_OPT_PRI_ADDR);
          end
        end
        LD_REQ: begin
          if (flashDataValid) begin
            if (byteIdx_reg == 2'h3) begin
              ldState_reg <= LD_DONE;
              flashRead <= 1'b0;
              optLoaded <= 1'b1;
            end else begin
              byteIdx_reg <= byteIdx_reg + 2'h1;
              flashAddr <= flashAddr + 20'h00001;
            end
          end
        end
        LD_DONE: begin
          ldState_reg <= LD_DONE;
        end
        default: begin
          ldState_reg <= LD_IDLE;
        end
      endcase
    end
  end

  // only loaded here, never written by software
  always @(posedge clock) begin
    if (!rst_b) begin
      optByte0_reg <= 8'hFF;
      optByte1_reg <= 8'hFF;
      optByte2_reg <= `SRO_RESERVED_OPT;
      optByte3_reg <= 8'hFF;
    end else if (ldState_reg == LD_REQ && flashDataValid) begin
      case (byteIdx_reg)
        2'h0: optByte0_reg <= flashData;
        2'h1: optByte1_reg <= flashData;
        2'h2: optByte2_reg <= flashData;
        default: optByte3_reg <= flashData;
      endcase
    end
  end

  always @(posedge clock) begin
    if (!rst_b) begin
      watchdogConfig <= 7'h00;
      watchdogIntervalIrqEnable <= 1'b0;
      supplyDropDetectorDefaultOn <= 1'b0;
      debugEnable <= 1'b0;
      debugEraseOnAuthFail <= 1'b0;
    end else begin
      watchdogConfig <= optByte0_reg[6:0];
      watchdogIntervalIrqEnable <= optByte0_reg[`SRO_WDT_IRQ_BIT];
      supplyDropDetectorDefaultOn <= optByte1_reg[0];
      debugEnable <= optByte3_reg[7];
      debugEraseOnAuthFail <= ~optByte3_reg[0];
    end
  end

  // ------------------------------------------------------------
  // standby state machine
  // ------------------------------------------------------------
  always @(posedge clock) begin
    if (!rst_b || systemReset) begin
      pwrState_reg <= ST_RUN;
      cpuClockEnable <= 1'b0;
      mainOscEnable <= 1'b1;
      stabStart <= 1'b0;
      xtalEnPrev_reg <= 1'b0;
    end else begin
      xtalEnPrev_reg <= xtalEn_reg;
      stabStart <= 1'b0;
      if (xtalEn_reg && !xtalEnPrev_reg && cpuSrc_reg != `SRO_SRC_XTAL) begin
        stabStart <= 1'b1;
      end
      case (pwrState_reg)
        ST_RUN: begin
          cpuClockEnable <= 1'b1;
          mainOscEnable <= 1'b1;
          if (apbWrite && hit(paddr, `SRO_OFF_CTRL) && pwdata[`SRO_CTRL_OSCOFF]) begin
            pwrState_reg <= ST_OSCOFF;
            cpuClockEnable <= 1'b0;
            mainOscEnable <= 1'b0;
          end else if (apbWrite && hit(paddr, `SRO_OFF_CTRL) && pwdata[`SRO_CTRL_IDLE]) begin
            pwrState_reg <= ST_IDLE;
            cpuClockEnable <= 1'b0;
          end
        end
        ST_IDLE: begin
          mainOscEnable <= 1'b1;
          if (pinSync[0]) begin
            pwrState_reg <= ST_RUN;
            cpuClockEnable <= 1'b1;
          end
        end
        ST_OSCOFF: begin
          if (pinSync[0]) begin
            mainOscEnable <= 1'b1;
            stabStart <= 1'b1;
            if (cpuSrc_reg == `SRO_SRC_XTAL) begin
              pwrState_reg <= ST_WAKE;
            end else begin
              pwrState_reg <= ST_RUN;
              cpuClockEnable <= 1'b1;
            end
          end
        end
        ST_WAKE: begin
          if (stabDone && !stabStart) begin
            pwrState_reg <= ST_RUN;
            cpuClockEnable <= 1'b1;
          end
        end
        default: begin
          pwrState_reg <= ST_RUN;
        end
      endcase
    end
  end

  // ------------------------------------------------------------
  // apb registers and interrupt
  // ------------------------------------------------------------
  always @(posedge clock) begin
    if (!rst_b) begin
      stab_time_select_reg <= `SRO_SEL_RESET;
      cpuSrc_reg <= `SRO_SRC_FAST;
      xtalEn_reg <= 1'b0;
      irqMask_reg <= 2'h0;
      irqStatus_reg <= 2'h0;
      prdata <= 32'h00000000;
      pready <= 1'b0;
      pslverr <= 1'b0;
      irq <= 1'b0;
    end else begin
      pready <= psel && penable && !pready;
      pslverr <= 1'b0;
      if (apbWrite && !pready) begin
        if (hit(paddr, `SRO_OFF_SEL)) begin
          stab_time_select_reg <= pwdata[2:0];
        end else if (hit(paddr, `SRO_OFF_CTRL)) begin
          cpuSrc_reg <= pwdata[`SRO_CTRL_CPUSRC_LO+1:`SRO_CTRL_CPUSRC_LO];
          xtalEn_reg <= pwdata[`SRO_CTRL_XTAL_EN];
        end else if (hit(paddr, `SRO_OFF_IRQMSK)) begin
          irqMask_reg <= pwdata[1:0];
        end else if (!hit(paddr, `SRO_OFF_OPT)) begin
          pslverr <= 1'b1;
        end
      end
      if (apbRead && !pready) begin
        case (paddr)
          `SRO_OFF_CTRL: prdata <= {27'h0, xtalEn_reg, cpuSrc_reg, pwrState_reg[1:0]};
          `SRO_OFF_SEL: prdata <= {29'h0, stab_time_select_reg};
          `SRO_OFF_STAT: prdata <= {23'h0, stabDone, stab_count_status};
          `SRO_OFF_OPT: prdata <= {optByte3_reg, optByte2_reg, optByte1_reg, optByte0_reg};
          `SRO_OFF_RSTCAUSE: prdata <= {27'h0, rstCause_reg};
          `SRO_OFF_IRQST: prdata <= {30'h0, irqStatus_reg};
          `SRO_OFF_IRQMSK: prdata <= {30'h0, irqMask_reg};
          default: begin
            prdata <= 32'h00000000;
            pslverr <= 1'b1;
          end
        endcase
      end
      // set beats read-clear; a set mask bit keeps its status bit off irq
      irqStatus_reg <= ((apbRead && !pready && hit(paddr, `SRO_OFF_IRQST)) ? 2'h0 : irqStatus_reg)
        | {(ldState_reg == LD_REQ && flashDataValid && byteIdx_reg == 2'h3), stabStart};
      irq <= |(irqStatus_reg & ~irqMask_reg);
    end
  end
endmodule

//--- dv/sro_standby_reset_props.sv
`include "sro_defs.vh"
module sro_standby_reset_props (
  input logic clock,
  input logic rst_b,
  input logic psel,
  input logic penable,
  input logic pready,
  input logic opcodeValid,
  input logic [7:0] opcode,
  input logic watchdogLoopReset,
  input logic bootSwap,
  input logic [19:0] flashAddr,
  input logic flashRead,
  input logic systemReset,
  input logic optLoaded,
  input logic mainOscEnable,
  input logic cpuClockEnable,
  input logic [6:0] watchdogConfig,
  input logic debugEnable,
  input logic supplyDropDetectorDefaultOn
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_b);
  // ----------------------------------------
  // bus and reset sequences
  // ----------------------------------------
  sequence accessWait;
    psel && penable && !pready;
  endsequence
  sequence illegalFetch;
    opcodeValid && opcode == `SRO_ILLEGAL_OPCODE;
  endsequence
  a_ready_one_wait: assert property (accessWait |=> pready)
    else $error("pready late");
  a_ready_single: assert property (pready |=> !pready)
    else $error("pready held");
  a_illegal_reset: assert property (illegalFetch |-> ##[1:4] systemReset)
    else $error("no reset on illegal opcode");
  a_wdt_reset: assert property (watchdogLoopReset |-> ##[1:4] systemReset)
    else $error("no reset on watchdog");
  a_reset_stretch: assert property ($rose(systemReset) |=> systemReset [*8])
    else $error("reset too short");
  a_load_first: assert property ($fell(systemReset) |-> optLoaded && $past(optLoaded))
    else $error("released before option load");
  a_opt_held: assert property (!systemReset && !$past(systemReset) |->
    $stable({watchdogConfig, debugEnable, supplyDropDetectorDefaultOn}))
    else $error("option outputs changed");
  a_flash_base: assert property ($rose(flashRead) |->
    flashAddr == (bootSwap ? `SRO_OPT_ALT_ADDR : `SRO_OPT_PRI_ADDR))
    else $error("wrong option block");
  a_osc_gates_cpu: assert property (!mainOscEnable |-> !cpuClockEnable)
    else $error("cpu clocked with oscillator off");
endmodule

//--- dv/testbench.sv
`include "sro_defs.vh"
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock = 0, rst_b = 0, psel = 0, penable = 0, pwrite = 0, wakeEvent = 0;
  logic extResetPin_b = 1, powerOnClear = 0, supplyDropReset = 0, watchdogLoopReset = 0;
  logic opcodeValid = 0, bootSwap = 0, flashDataValid = 0, er;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, rd, img[2];
  logic [7:0] opcode = 0, flashData = 0;
  wire [31:0] prdata;
  wire [19:0] flashAddr;
  wire [6:0] watchdogConfig;
  wire pready, pslverr, flashRead, systemReset, cpuClockEnable, mainOscEnable, optLoaded, irq;
  wire watchdogIntervalIrqEnable, supplyDropDetectorDefaultOn, debugEnable, debugEraseOnAuthFail;
  int fail_count = 0, samples_checked = 0, cyc = 0, t0, k, sel;
  sro_standby_reset #(.STAB_BASE(4)) dut (.clock, .rst_b, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .extResetPin_b, .powerOnClear, .supplyDropReset,
    .watchdogLoopReset, .opcodeValid, .opcode, .wakeEvent, .bootSwap, .flashAddr, .flashRead,
    .flashData, .flashDataValid, .systemReset, .cpuClockEnable, .mainOscEnable, .optLoaded,
    .watchdogConfig, .watchdogIntervalIrqEnable, .supplyDropDetectorDefaultOn, .debugEnable,
    .debugEraseOnAuthFail, .irq);
  always #12.5 clock = ~clock;
  // ----------------------------------------
  // option flash image, one byte per pulse
  // ----------------------------------------
  always @(posedge clock) begin
    cyc <= cyc + 1;
    flashDataValid <= flashRead && !flashDataValid;
    flashData <= img[flashAddr[12]][8*flashAddr[1:0] +: 8];
  end
  task chk(input logic [31:0] s, input logic [31:0] e);
    samples_checked++;
    if (s !== e) begin
      fail_count++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int t;
    t = 0;
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1;
    do begin
      @(posedge clock);
      t++;
    end while (pready !== 1'b1 && t < 40);
    rd = prdata;
    er = pslverr;
    psel <= 0;
    penable <= 0;
    if (t >= 40) fail_count++;
    @(posedge clock);
  endtask
  task wait_cpu_on;
    while (cpuClockEnable !== 1'b1 && cyc - t0 < 3000) @(posedge clock);
  endtask
  task chkopt(input int b);
    logic [31:0] v;
    v = img[b];
    t0 = cyc;
    repeat (3) @(posedge clock);
    while (systemReset !== 1'b0 && cyc - t0 < 500) @(posedge clock);
    apb(0, `SRO_OFF_OPT, 0);
    chk(rd, v);
    chk({watchdogConfig, watchdogIntervalIrqEnable, supplyDropDetectorDefaultOn, debugEnable,
      debugEraseOnAuthFail}, {v[6:0], v[7], v[8], v[31], ~v[24]});
  endtask
  task final_report;
    if (fail_count == 0 && samples_checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    void'($urandom(4));
    for (k = 0; k < 2; k++) img[k] = $urandom | 32'h00FF0000;
    repeat (12) @(posedge clock);
    rst_b <= 1;
    chkopt(0);
    apb(1, `SRO_OFF_IRQMSK, 3);
    chk(irq, 0);
    apb(1, `SRO_OFF_IRQMSK, 0);
    chk(irq, 1);
    apb(0, `SRO_OFF_IRQST, 0);
    chk(rd, 2);
    chk(irq, 0);
    apb(0, 12'h01C, 0);
    chk(er, 1);
    apb(1, `SRO_OFF_STAT, 0);
    chk(er, 1);
    apb(1, `SRO_OFF_OPT, ~img[0]);
    chkopt(0);
    apb(0, `SRO_OFF_SEL, 0);
    chk(rd, `SRO_SEL_RESET);
    apb(0, `SRO_OFF_RSTCAUSE, 0);
    opcode <= 8'hFF;
    repeat (4) @(posedge clock);
    chk(systemReset, 0);
    for (k = 0; k < 5; k++) begin
      bootSwap <= k[0];
      extResetPin_b <= k != 0;
      watchdogLoopReset <= k == 1;
      powerOnClear <= k == 2;
      supplyDropReset <= k == 3;
      opcodeValid <= k == 4;
      repeat (4) @(posedge clock);
      {watchdogLoopReset, powerOnClear, supplyDropReset, opcodeValid} <= 0;
      extResetPin_b <= 1;
      chkopt(k % 2);
      apb(0, `SRO_OFF_RSTCAUSE, 0);
      chk(rd, 32'h10 >> k);
    end
    for (k = 0; k < 2; k++) begin
      sel = $urandom % 8;
      apb(1, `SRO_OFF_SEL, sel);
      apb(1, `SRO_OFF_CTRL, k ? 32'h12 : 32'h1A);
      chk({cpuClockEnable, mainOscEnable}, 0);
      wakeEvent <= 1;
      t0 = cyc;
      if (k) begin
        repeat (8) @(posedge clock);
        chk(cpuClockEnable, 1);
        rd = 0;
        while (!rd[8] && cyc - t0 < 3000) apb(0, `SRO_OFF_STAT, 0);
      end else wait_cpu_on;
      chk(cyc - t0 >= (4 << sel) && cyc - t0 <= (4 << sel) + 40, 1);
      apb(0, `SRO_OFF_STAT, 0);
      chk(rd[8:0], 32'h100 | ((2 << sel) - 1));
      wakeEvent <= 0;
    end
    // let the synchronised wake level drop before idling
    repeat (6) @(posedge clock);
    apb(1, `SRO_OFF_CTRL, 1);
    chk({cpuClockEnable, mainOscEnable}, 1);
    wakeEvent <= 1;
    t0 = cyc;
    wait_cpu_on;
    chk(cpuClockEnable, 1);
    wakeEvent <= 0;
    // crystal start while the sub clock drives the cpu
    apb(1, `SRO_OFF_CTRL, 32'h14);
    t0 = cyc;
    rd = 0;
    while (!rd[8] && cyc - t0 < 3000) apb(0, `SRO_OFF_STAT, 0);
    chk(rd[8:0], 32'h100 | ((2 << sel) - 1));
    final_report;
  end
  initial begin
    #750000;
    fail_count++;
    final_report;
  end
endmodule
bind sro_standby_reset sro_standby_reset_props props (.clock, .rst_b, .psel, .penable, .pready,
  .opcodeValid, .opcode, .watchdogLoopReset, .bootSwap, .flashAddr, .flashRead, .systemReset,
  .optLoaded, .mainOscEnable, .cpuClockEnable, .watchdogConfig, .debugEnable,
  .supplyDropDetectorDefaultOn);
